// *** pfcp_cfg.svh ***
// constants for the parallel flash command port host
`ifndef PFCP_CFG_SVH
`define PFCP_CFG_SVH

// widths
`define PFCP_ADDR_W 17
`define PFCP_TMR_W 19

// command bytes
`define PFCP_CMD_READ 8'h00
`define PFCP_CMD_PROG 8'h40
`define PFCP_CMD_PVER 8'hC0
`define PFCP_CMD_ERASE 8'h20
`define PFCP_CMD_EVER 8'hA0
`define PFCP_CMD_RESET 8'hFF
`define PFCP_CMD_IDENT 8'h90

// identification_address values
`define PFCP_ID_ADDR_MAKER 17'h0_0000
`define PFCP_ID_ADDR_DEVICE 17'h0_0001

// times in ns, cycle counts rounded up (all are least times)
`define PFCP_CLK_NS 25
`define PFCP_T_WP_NS 60
`define PFCP_T_WPH_NS 20
`define PFCP_T_ACC_NS 150
`define PFCP_T_VSC_NS 1000
`define PFCP_T_WRR_NS 6000
`define PFCP_T_PROG_NS 10000
`define PFCP_T_ERASE_NS 9500000
`define PFCP_CYC(t) (((t) + `PFCP_CLK_NS - 1) / `PFCP_CLK_NS)
`define PFCP_WP_CYC `PFCP_CYC(`PFCP_T_WP_NS)
`define PFCP_WPH_CYC `PFCP_CYC(`PFCP_T_WPH_NS)
`define PFCP_ACC_CYC `PFCP_CYC(`PFCP_T_ACC_NS)
`define PFCP_VSC_CYC `PFCP_CYC(`PFCP_T_VSC_NS)
`define PFCP_WRR_CYC `PFCP_CYC(`PFCP_T_WRR_NS)
`define PFCP_PROG_CYC `PFCP_CYC(`PFCP_T_PROG_NS)
`define PFCP_ERASE_CYC `PFCP_CYC(`PFCP_T_ERASE_NS)

`endif

// *** pfcp_pkg.sv ***
// types shared by the parallel flash command port host
package pfcp_pkg;

   // operations that the user side may request
   typedef enum logic [2:0] {
      OP_READ  = 3'h0,
      OP_PROG  = 3'h1,
      OP_PVER  = 3'h2,
      OP_ERASE = 3'h3,
      OP_EVER  = 3'h4,
      OP_RESET = 3'h5,
      OP_IDENT = 3'h6
   } pfcp_op_t;

endpackage

// *** pfcp_cyc_if.sv ***
// one pin-level bus cycle request between sequencer and pin engine
`timescale 1ns/1ps
`default_nettype none
interface pfcp_cyc_if;
   logic        req;    // level, held until done
   logic        wr;     // 1 write cycle, 0 read cycle
   logic [16:0] addr;
   logic [7:0]  wdata;
   logic        done;   // one-cycle pulse at end of cycle
   logic [7:0]  rdata;

   modport ctrl (output req, wr, addr, wdata, input done, rdata);
   modport eng  (input req, wr, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

// *** pfcp_pin_cycle.sv ***
// pin engine: one write strobe cycle or one read cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
`include "pfcp_cfg.svh"
module pfcp_pin_cycle (
   // clock, reset, enable
   input  wire logic        ref_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        ce_i,
   // request from sequencer
   pfcp_cyc_if.eng          cyc,
   // flash pins
   output logic             flash_ce_n_o,
   output logic             flash_oe_n_o,
   output logic             flash_we_n_o,
   output logic [16:0]      flash_addr_o,
   output logic [7:0]       flash_data_o,
   output logic             flash_data_oe_o,
   input  wire logic [7:0]  flash_data_i
);
   typedef enum logic [4:0] {
      E_IDLE  = 5'b0_0001,
      E_SETUP = 5'b0_0010,
      E_WLOW  = 5'b0_0100,
      E_WHIGH = 5'b0_1000,
      E_RACC  = 5'b1_0000
   } pfcp_eng_st_t;

   pfcp_eng_st_t st_q;
   logic [2:0]   cnt_q;
   logic         done_q;
   logic [7:0]   rdata_q;

   assign cyc.done  = done_q;
   assign cyc.rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // cycle sequencer; done_q gates a fresh start so a held req is not
   // mistaken for a second request in the cycle that it ends
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         st_q            <= E_IDLE;
         cnt_q           <= 3'h0;
         done_q          <= 1'b0;
         rdata_q         <= 8'h00;
         flash_ce_n_o    <= 1'b1;
         flash_oe_n_o    <= 1'b1;
         flash_we_n_o    <= 1'b1;
         flash_addr_o    <= 17'h0_0000;
         flash_data_o    <= 8'h00;
         flash_data_oe_o <= 1'b0;
      end else if (ce_i) begin
         done_q <= 1'b0;
         case (st_q)
            E_IDLE: begin
               if (cyc.req && !done_q) begin
                  flash_addr_o <= cyc.addr;
                  flash_ce_n_o <= 1'b0;
                  cnt_q        <= 3'h0;
                  if (cyc.wr) begin
                     // oe stays high so write state is legal
                     flash_data_o    <= cyc.wdata;
                     flash_data_oe_o <= 1'b1;
                     st_q            <= E_SETUP;
                  end else begin
                     flash_oe_n_o <= 1'b0;
                     st_q         <= E_RACC;
                  end
               end
            end
            E_SETUP: begin
               // address is stable before the falling strobe
               flash_we_n_o <= 1'b0;
               st_q         <= E_WLOW;
            end
            E_WLOW: begin
               cnt_q <= cnt_q + 3'h1;
               if (cnt_q == 3'(`PFCP_WP_CYC - 1)) begin
                  // byte taken on this rising strobe
                  flash_we_n_o <= 1'b1;
                  cnt_q        <= 3'h0;
                  st_q         <= E_WHIGH;
               end
            end
            E_WHIGH: begin
               cnt_q <= cnt_q + 3'h1;
               if (cnt_q == 3'(`PFCP_WPH_CYC - 1)) begin
                  // release data and chip enable in the same cycle
                  flash_ce_n_o    <= 1'b1;
                  flash_data_oe_o <= 1'b0;
                  done_q          <= 1'b1;
                  st_q            <= E_IDLE;
               end
            end
            E_RACC: begin
               cnt_q <= cnt_q + 3'h1;
               if (cnt_q == 3'(`PFCP_ACC_CYC - 1)) begin
                  rdata_q      <= flash_data_i;
                  flash_oe_n_o <= 1'b1;
                  flash_ce_n_o <= 1'b1;
                  done_q       <= 1'b1;
                  st_q         <= E_IDLE;
               end
            end
            default: begin
               st_q <= E_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks on strobe shapes
   sequence s_we_low3;
      !flash_we_n_o [*3] ##1 flash_we_n_o;
   endsequence
   sequence s_oe_low6;
      !flash_oe_n_o [*6] ##1 flash_oe_n_o;
   endsequence

   a_we_pulse_width: assert property (
      @(posedge ref_clk_i) disable iff (!reset_n_i || !ce_i)
      $fell(flash_we_n_o) |-> s_we_low3)
      else $error("write strobe low time wrong");

   a_read_access: assert property (
      @(posedge ref_clk_i) disable iff (!reset_n_i || !ce_i)
      $fell(flash_oe_n_o) |-> s_oe_low6 ##0 done_q)
      else $error("read access time wrong");

   a_addr_held_strobe: assert property (
      @(posedge ref_clk_i) disable iff (!reset_n_i || !ce_i)
      !flash_we_n_o |-> $stable(flash_addr_o) && flash_data_oe_o)
      else $error("address or data moved under write strobe");
endmodule
`default_nettype wire

// *** pfcp_host.sv ***
// host sequencer driving the parallel flash command port pins
`timescale 1ns/1ps
`default_nettype none
`include "pfcp_cfg.svh"
module pfcp_host #(
   parameter int unsigned ERASE_CYC = `PFCP_ERASE_CYC
) (
   // clock, reset, enable
   input  wire logic              ref_clk_i,
   input  wire logic              reset_n_i,
   input  wire logic              ce_i,
   // mode select
   input  wire logic              rw_mode_i,
   // command request
   input  wire logic              cmd_valid_i,
   output logic                   cmd_ready_o,
   input  wire pfcp_pkg::pfcp_op_t cmd_op_i,
   input  wire logic [16:0]       cmd_addr_i,
   input  wire logic [7:0]        cmd_data_i,
   // response
   output logic                   rsp_valid_o,
   output logic [7:0]             rsp_data_o,
   output logic                   rsp_err_o,
   // flash pins
   output logic                   flash_vpp_high_o,
   output logic                   flash_ce_n_o,
   output logic                   flash_oe_n_o,
   output logic                   flash_we_n_o,
   output logic [16:0]            flash_addr_o,
   output logic [7:0]             flash_data_o,
   output logic                   flash_data_oe_o,
   input  wire logic [7:0]        flash_data_i
);
   import pfcp_pkg::*;

   typedef enum logic [6:0] {
      ST_IDLE = 7'b000_0001,
      ST_VPP  = 7'b000_0010,
      ST_WR1  = 7'b000_0100,
      ST_WR2  = 7'b000_1000,
      ST_TMR  = 7'b001_0000,
      ST_RD   = 7'b010_0000,
      ST_RSP  = 7'b100_0000
   } pfcp_st_t;

   pfcp_st_t                 state_q;
   pfcp_op_t                 op_q;
   logic [16:0]              addr_q;
   logic [16:0]              prog_addr_q;
   logic [7:0]               data_q;
   logic [7:0]               latch_q;
   logic [5:0]               vpp_cnt_q;
   logic                     vpp_ready;
   logic [`PFCP_TMR_W-1:0]   tmr_q;

   pfcp_cyc_if cyc ();

   ////////////////////////////////////////////////////////////////////////
   // decoders used by the sequencer and the cycle request
   function automatic logic [7:0] first_byte(input pfcp_op_t op);
      case (op)
         OP_READ:  first_byte = `PFCP_CMD_READ;
         OP_PROG:  first_byte = `PFCP_CMD_PROG;
         OP_PVER:  first_byte = `PFCP_CMD_PVER;
         OP_ERASE: first_byte = `PFCP_CMD_ERASE;
         OP_EVER:  first_byte = `PFCP_CMD_EVER;
         OP_RESET: first_byte = `PFCP_CMD_RESET;
         OP_IDENT: first_byte = `PFCP_CMD_IDENT;
         default:  first_byte = `PFCP_CMD_READ;
      endcase
   endfunction

   function automatic logic has_wr2(input pfcp_op_t op);
      has_wr2 = (op == OP_PROG) || (op == OP_ERASE) || (op == OP_RESET);
   endfunction

   function automatic logic has_read(input pfcp_op_t op);
      has_read = (op == OP_READ) || (op == OP_PVER) ||
                 (op == OP_EVER) || (op == OP_IDENT);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // cycle request; program verify needs no address, the last program
   // address is driven only so that the bus is not left at random
   always_comb begin
      cyc.req   = (state_q == ST_WR1) || (state_q == ST_WR2) ||
                  (state_q == ST_RD);
      cyc.wr    = (state_q != ST_RD);
      cyc.addr  = (op_q == OP_PVER) ? prog_addr_q : addr_q;
      cyc.wdata = first_byte(op_q);
      if (state_q == ST_WR2) begin
         // erase and reset repeat their byte, program sends data
         cyc.wdata = (op_q == OP_PROG) ? data_q : first_byte(op_q);
      end
   end

   pfcp_pin_cycle u_pin (
      .ref_clk_i       (ref_clk_i),
      .reset_n_i       (reset_n_i),
      .ce_i            (ce_i),
      .cyc             (cyc.eng),
      .flash_ce_n_o    (flash_ce_n_o),
      .flash_oe_n_o    (flash_oe_n_o),
      .flash_we_n_o    (flash_we_n_o),
      .flash_addr_o    (flash_addr_o),
      .flash_data_o    (flash_data_o),
      .flash_data_oe_o (flash_data_oe_o),
      .flash_data_i    (flash_data_i)
   );

   ////////////////////////////////////////////////////////////////////////
   // supply level follows the mode input only in idle, also on the edge that takes a
   // command, so the mode can change as a command starts; setup time counted after rising
   assign vpp_ready = (vpp_cnt_q == 6'(`PFCP_VSC_CYC));
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         flash_vpp_high_o <= 1'b0;
         vpp_cnt_q        <= 6'h00;
      end else if (ce_i) begin
         if (state_q == ST_IDLE) begin
            flash_vpp_high_o <= rw_mode_i;
         end
         if (!flash_vpp_high_o) begin
            vpp_cnt_q <= 6'h00;
         end else if (!vpp_ready) begin
            vpp_cnt_q <= vpp_cnt_q + 6'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // host copy of the device command latch
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         latch_q <= `PFCP_CMD_READ;
      end else if (ce_i && cyc.done) begin
         if (state_q == ST_WR1) begin
            latch_q <= first_byte(op_q);
         end else if (state_q == ST_WR2 && op_q == OP_RESET) begin
            latch_q <= `PFCP_CMD_READ;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // operation sequencer
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         state_q     <= ST_IDLE;
         op_q        <= OP_READ;
         addr_q      <= 17'h0_0000;
         prog_addr_q <= 17'h0_0000;
         data_q      <= 8'h00;
         tmr_q       <= '0;
         rsp_data_o  <= 8'h00;
         rsp_err_o   <= 1'b0;
      end else if (ce_i) begin
         case (state_q)
            ST_IDLE: begin
               if (cmd_valid_i) begin
                  op_q      <= cmd_op_i;
                  addr_q    <= cmd_addr_i;
                  data_q    <= cmd_data_i;
                  rsp_err_o <= 1'b0;
                  if (cmd_op_i == OP_READ &&
                      (latch_q == `PFCP_CMD_READ || !flash_vpp_high_o)) begin
                     state_q <= ST_RD;
                  end else if (!flash_vpp_high_o) begin
                     // nothing but reads in read-only mode
                     rsp_err_o <= 1'b1;
                     state_q   <= ST_RSP;
                  end else begin
                     state_q <= ST_VPP;
                  end
               end
            end
            ST_VPP: begin
               if (vpp_ready) begin
                  state_q <= ST_WR1;
               end
            end
            ST_WR1: begin
               if (cyc.done) begin
                  if (has_wr2(op_q)) begin
                     state_q <= ST_WR2;
                  end else begin
                     tmr_q   <= `PFCP_TMR_W'(`PFCP_WRR_CYC - 1);
                     state_q <= ST_TMR;
                  end
               end
            end
            ST_WR2: begin
               if (cyc.done) begin
                  state_q <= ST_TMR;
                  if (op_q == OP_PROG) begin
                     prog_addr_q <= addr_q;
                     tmr_q <= `PFCP_TMR_W'(`PFCP_PROG_CYC - 1);
                  end else if (op_q == OP_ERASE) begin
                     // zero fill beforehand is left to the caller
                     tmr_q <= `PFCP_TMR_W'(ERASE_CYC - 1);
                  end else begin
                     state_q <= ST_RSP;
                  end
               end
            end
            ST_TMR: begin
               // pins stay idle until the internal timer is surely over
               if (tmr_q == '0) begin
                  state_q <= has_read(op_q) ? ST_RD : ST_RSP;
               end else begin
                  tmr_q <= tmr_q - `PFCP_TMR_W'(1);
               end
            end
            ST_RD: begin
               if (cyc.done) begin
                  rsp_data_o <= cyc.rdata;
                  state_q    <= ST_RSP;
               end
            end
            ST_RSP: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // handshakes are decoded straight from the state
   assign cmd_ready_o = (state_q == ST_IDLE);
   assign rsp_valid_o = (state_q == ST_RSP);

   ////////////////////////////////////////////////////////////////////////
   // checks on pin discipline and sequencing
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i || !ce_i);

   a_ro_no_write: assert property (
      !flash_vpp_high_o |-> flash_we_n_o)
      else $error("write strobe in read-only mode");

   a_vpp_before_we: assert property (
      $fell(flash_we_n_o) |-> flash_vpp_high_o && vpp_ready)
      else $error("strobe before supply setup");

   a_write_state: assert property (
      !flash_we_n_o |-> flash_oe_n_o && !flash_ce_n_o)
      else $error("write strobe with bad enables");

   a_read_no_drive: assert property (
      !flash_oe_n_o |-> !flash_data_oe_o && !flash_ce_n_o)
      else $error("host drives data during read");

   a_standby_float: assert property (
      flash_ce_n_o |-> !flash_data_oe_o && flash_we_n_o)
      else $error("activity in standby");

   a_timer_quiet: assert property (
      state_q == ST_TMR |-> flash_ce_n_o ##0 !cyc.req)
      else $error("pins used while device timer runs");

   a_read_skip: assert property (
      (state_q == ST_IDLE && cmd_valid_i && cmd_op_i == OP_READ &&
       latch_q == `PFCP_CMD_READ) |=> state_q == ST_RD ##1 !flash_oe_n_o)
      else $error("read did not go straight to second cycle");

   a_prog_timer: assert property (
      (state_q == ST_WR2 && cyc.done && op_q == OP_PROG) |=>
      state_q == ST_TMR && tmr_q == `PFCP_TMR_W'(`PFCP_PROG_CYC - 1))
      else $error("program wait not loaded");

   a_reset_latch: assert property (
      (state_q == ST_WR2 && cyc.done && op_q == OP_RESET) |=>
      latch_q == `PFCP_CMD_READ && rsp_valid_o)
      else $error("reset did not return to read");
endmodule
`default_nettype wire

// *** pfcp_flash_model.sv ***
// behavioural flash array answering the host's parallel pins
`timescale 1ns/1ps
`default_nettype none
`include "pfcp_cfg.svh"
module pfcp_flash_model #(
   parameter logic [7:0] MAKER_CODE = 8'h6B, // arbitrary value
   parameter logic [7:0] DEV_CODE   = 8'h9E, // arbitrary value
   parameter int         PROG_NS    = 9000,
   parameter int         ERASE_NS   = 1000
) (
   // clock for the floating pattern only
   input  wire logic        clk_i,
   // supply and control pins
   input  wire logic        vpp_high_i,
   input  wire logic        ce_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic [16:0] addr_i,
   // host side of the data pins
   input  wire logic [7:0]  host_data_i,
   input  wire logic        host_data_oe_i,
   // resolved data pins
   output logic [7:0]       data_o,
   output logic             clash_o
);
   logic [7:0]  mem [logic [16:0]];
   logic [7:0]  latch_q  = `PFCP_CMD_READ; // power-on read mode
   logic        second_q = 1'b0;
   logic        busy_q   = 1'b0;
   logic [16:0] addr_q   = '0;
   logic [16:0] prog_a_q = '0;
   logic [16:0] ever_a_q = '0;
   logic [7:0]  prog_d_q = '0;
   logic [7:0]  float_q  = 8'h00;
   logic [7:0]  rd_d;
   logic        drive_d;
   wire logic   wr_ok = !ce_n_i && oe_n_i && vpp_high_i;

   function automatic logic [7:0] peek(input logic [16:0] a);
      return mem.exists(a) ? mem[a] : 8'hFF; // unwritten cells read erased
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // undriven pins wander, so a stale byte never passes for read data
   always @(posedge clk_i) float_q <= float_q + 8'h3B;

   // output only in the read state, chosen by the latch
   always @* begin
      drive_d = !ce_n_i && !oe_n_i && we_n_i;
      rd_d    = 8'h00;
      case (latch_q)
         `PFCP_CMD_READ: rd_d = peek(addr_i);
         `PFCP_CMD_PVER: rd_d = busy_q ? ~peek(prog_a_q)
                                       : peek(prog_a_q);
         `PFCP_CMD_EVER: rd_d = busy_q ? 8'h00 : peek(ever_a_q);
         `PFCP_CMD_IDENT: rd_d = (addr_i == `PFCP_ID_ADDR_DEVICE)
                                 ? DEV_CODE : MAKER_CODE;
         default: drive_d = 1'b0;
      endcase
   end
   assign data_o  = host_data_oe_i ? host_data_i : drive_d ? rd_d : float_q;
   assign clash_o = host_data_oe_i && drive_d;

   // address taken on the falling strobe
   always @(negedge we_n_i) if (wr_ok) addr_q = addr_i;

   // bytes on the rising strobe; the timers block here, which is safe
   // because a host must wait them out anyway
   always @(posedge we_n_i) if (wr_ok) begin
      if (!second_q) begin
         latch_q  = host_data_i;
         second_q = host_data_i inside {`PFCP_CMD_PROG, `PFCP_CMD_ERASE,
                                        `PFCP_CMD_RESET};
         if (host_data_i == `PFCP_CMD_EVER) ever_a_q = addr_q;
      end else if (host_data_i == `PFCP_CMD_RESET) begin
         // cancel leaves memory alone
         second_q = (latch_q != `PFCP_CMD_RESET);
         latch_q  = second_q ? `PFCP_CMD_RESET : `PFCP_CMD_READ;
      end else begin
         second_q = 1'b0;
         busy_q   = 1'b1;
         if (latch_q == `PFCP_CMD_PROG) begin
            prog_a_q = addr_q;
            prog_d_q = host_data_i;
            #(PROG_NS) mem[prog_a_q] = prog_d_q;
         end else if (host_data_i == `PFCP_CMD_ERASE) begin
            #(ERASE_NS) mem.delete();
         end
         busy_q = 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** pfcp_host_tb.sv ***
// self-checking bench for the flash command port host
`timescale 1ns/1ps
`default_nettype none
`include "pfcp_cfg.svh"
module pfcp_host_tb;
   import pfcp_pkg::*;
   localparam int         ERASE_CYC = 50; // short erase for simulation
   localparam logic [7:0] MAKER     = 8'h6B; // arbitrary value
   localparam logic [7:0] DEVICE    = 8'h9E; // arbitrary value
   logic        ref_clk = 1'b0, reset_n = 1'b0, ce = 1'b1, rw_mode = 1'b0;
   logic        cmd_valid = 1'b0;
   pfcp_op_t    cmd_op = OP_READ;
   logic [16:0] cmd_addr = '0, addr;
   logic [7:0]  cmd_data = '0, rsp_data, host_d, bus;
   logic        cmd_ready, rsp_valid, rsp_err, vpp_high, ce_n, oe_n, we_n;
   logic        data_oe, clash;
   int          fail_count = 0, tests_run = 0, we_falls = 0;

   pfcp_host #(.ERASE_CYC(ERASE_CYC)) pfcp_host_inst (
      .ref_clk_i(ref_clk), .reset_n_i(reset_n), .ce_i(ce),
      .rw_mode_i(rw_mode), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
      .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
      .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_err_o(rsp_err),
      .flash_vpp_high_o(vpp_high), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
      .flash_we_n_o(we_n), .flash_addr_o(addr), .flash_data_o(host_d),
      .flash_data_oe_o(data_oe), .flash_data_i(bus));
   pfcp_flash_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEVICE))
      pfcp_flash_model_inst (
      .clk_i(ref_clk), .vpp_high_i(vpp_high), .ce_n_i(ce_n), .oe_n_i(oe_n),
      .we_n_i(we_n), .addr_i(addr), .host_data_i(host_d),
      .host_data_oe_i(data_oe), .data_o(bus), .clash_o(clash));

   ////////////////////////////////////////////////////////////////////////
   // 40 MHz clock and a count of write strobes seen on the pins
   always #12.5 ref_clk = ~ref_clk;
   always @(negedge we_n) we_falls++;
   always @(posedge ref_clk) if (clash === 1'b1) fail("data bus fight");

   task automatic fail(input string m);
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
   endtask

   task automatic check(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) fail(m);
   endtask

   task automatic summarize();
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // one request, an optional clock-enable stall, then the response
   task automatic run_op(input pfcp_op_t o, input logic [16:0] a,
      input logic [7:0] d, input int stall, input logic e_err,
      input logic [7:0] e_d);
      int   n;
      logic rdy;
      cmd_op    = o;
      cmd_addr  = a;
      cmd_data  = d;
      cmd_valid = 1'b1;
      n = 0;
      do begin
         rdy = cmd_ready;
         @(posedge ref_clk);
         #2;
         n++;
      end while (rdy !== 1'b1 && n < 50);
      cmd_valid = 1'b0;
      if (rdy !== 1'b1) begin
         fail("request not taken");
         summarize();
      end
      if (stall > 0) begin
         ce = 1'b0;
         repeat (stall) @(posedge ref_clk);
         #2;
         ce = 1'b1;
      end
      n = 0;
      while (rsp_valid !== 1'b1 && n < 2000) begin
         @(posedge ref_clk);
         #2;
         n++;
      end
      if (n >= 2000) begin
         fail("no response");
         summarize();
      end
      check(rsp_err === e_err, "refusal flag");
      if (!e_err && o inside {OP_READ, OP_PVER, OP_EVER, OP_IDENT})
         check(rsp_data === e_d, "returned byte");
      check(ce_n === 1'b1 && data_oe === 1'b0, "pins not parked");
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_read_only();
      int w;
      pfcp_flash_model_inst.mem[17'h0_1234] = 8'hC3;
      run_op(OP_READ, 17'h0_1234, 8'h00, 3, 1'b0, 8'hC3);
      w = we_falls;
      run_op(OP_PROG, 17'h0_1234, 8'h11, 0, 1'b1, 8'h00);
      check(we_falls == w && vpp_high === 1'b0, "write when read-only");
   endtask

   task automatic t_program();
      int w;
      rw_mode = 1'b1;
      // the supply follows the mode only from idle, one edge later
      repeat (2) @(posedge ref_clk);
      #2;
      w = we_falls;
      run_op(OP_PROG, 17'h0_1234, 8'h5A, 0, 1'b0, 8'h00);
      check(we_falls == w + 2 && vpp_high === 1'b1, "program");
      run_op(OP_PVER, 17'h1_FFFF, 8'h00, 0, 1'b0, 8'h5A);
      run_op(OP_READ, 17'h0_1234, 8'h00, 0, 1'b0, 8'h5A);
      w = we_falls;
      run_op(OP_READ, 17'h0_1235, 8'h00, 5, 1'b0, 8'hFF);
      check(we_falls == w, "second read wrote a command");
   endtask

   task automatic t_ident();
      int w;
      w = we_falls;
      run_op(OP_IDENT, `PFCP_ID_ADDR_MAKER, 8'h00, 0, 1'b0, MAKER);
      run_op(OP_IDENT, `PFCP_ID_ADDR_DEVICE, 8'h00, 0, 1'b0, DEVICE);
      check(we_falls == w + 2, "command not reissued");
   endtask

   task automatic t_erase();
      int w;
      run_op(OP_PROG, 17'h0_1234, 8'h00, 0, 1'b0, 8'h00);
      w = we_falls;
      run_op(OP_ERASE, 17'h0_0000, 8'h00, 0, 1'b0, 8'h00);
      check(we_falls == w + 2, "erase strobes");
      run_op(OP_EVER, 17'h0_1234, 8'h00, 0, 1'b0, 8'hFF);
   endtask

   task automatic t_reset();
      run_op(OP_PROG, 17'h0_0100, 8'h33, 0, 1'b0, 8'h00);
      run_op(OP_RESET, 17'h0_0000, 8'h00, 0, 1'b0, 8'h00);
      run_op(OP_READ, 17'h0_0100, 8'h00, 0, 1'b0, 8'h33);
   endtask

   // reset for 12 cycles, then the scenarios in turn
   initial begin
      repeat (12) @(posedge ref_clk);
      #2;
      reset_n = 1'b1;
      t_read_only();
      t_program();
      t_ident();
      t_erase();
      t_reset();
      summarize();
   end
endmodule
`default_nettype wire
